//--- fan_port_pkg.sv
package fan_port_pkg;
  localparam logic [6:0] SLAVE_ADDR        = 7'h55;
  localparam logic [7:0] DUTY_REG          = 8'ha5;
  localparam logic [7:0] PARAM_BASE        = 8'h40;
  localparam logic [7:0] PARAM_FIRST       = 8'h41;
  localparam logic [7:0] PARAM_LAST        = 8'h54;
  localparam int         NV_WORDS          = 21;
  localparam int         DUTY_W            = 9;
  localparam logic [8:0] DUTY_FULL         = 9'h1ff;
  localparam logic [8:0] DUTY_ZERO         = 9'h000;
  localparam logic [8:0] DUTY_RESET        = 9'h000;
  // Word 15 fields
  localparam int         W_DRIVE           = 15;
  localparam int         POST_COAST_BIT    = 0;
  localparam int         STANDBY_OFF_BIT   = 1;
  localparam int         FREQ_LO           = 2;
  localparam int         TEMP_COMP_BIT     = 6;
  localparam int         OC_LEVEL_LO       = 13;
  localparam int         OC_OFF_BIT        = 15;
  localparam logic [15:0] DRIVE_RESET      = 16'h0409;
  // Word 16 fields, then word 19 slope speed and post-coast times
  localparam int         W_RUN             = 16;
  localparam int         LOOP_BIT          = 0;
  localparam int         ADVANCE_BIT       = 1;
  localparam int         SOURCE_BIT        = 3;
  localparam int         POLE_LO           = 4;
  localparam int         NO_COAST_BIT      = 7;
  localparam int         ALIGN_BIT         = 8;
  localparam int         TACH_START_BIT    = 11;
  localparam int         OC_RECOVERY_BIT   = 15;
  localparam logic [15:0] RUN_RESET        = 16'h5191;
  localparam int         W_SLOPE_SPEED     = 19;
  localparam logic [15:0] SLOPE_SPEED_RESET = 16'h07d0;
  localparam int         SLOPE_SPEED_W     = 15;
  localparam int         POST_COAST_SHORT_MS = 100;
  localparam int         POST_COAST_LONG_MS  = 500;
  // Link clock divider, one bit phase in clk_sys cycles; three phases per bit (40 MHz / 3*20 = about 667 kHz)
  localparam int         SCL_HALF          = 20;
endpackage

//--- fan_link_if.sv
`timescale 1ns/100ps
`default_nettype none
interface fan_link_if;
  logic scl_out;
  logic scl_oe_n;
  logic sda_master_out;
  logic sda_master_oe_n;
  logic sda_device_out;
  logic sda_device_oe_n;
  wire  scl = ~scl_oe_n ? scl_out : 1'b1;
  wire  sda = (~sda_master_oe_n & ~sda_master_out) | (~sda_device_oe_n & ~sda_device_out)
              ? 1'b0 : 1'b1;
  modport device (input scl, input sda, output sda_device_out, output sda_device_oe_n);
  modport master (input scl, input sda, output scl_out, output scl_oe_n,
                  output sda_master_out, output sda_master_oe_n);
endinterface
`default_nettype wire

//--- pin_sync.sv
`timescale 1ns/100ps
`default_nettype none
module pin_sync #(
  parameter int W = 2
) (
  input  wire logic         clk_sys,
  input  wire logic         rst_n,
  input  wire logic [W-1:0] raw,
  output logic      [W-1:0] synced
);
  logic [W-1:0] meta;
  // Idle bus level is high, so both stages reset high
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      meta   <= '1;
      synced <= '1;
    end else begin
      meta   <= raw;
      synced <= meta;
    end
  end
endmodule
`default_nettype wire

//--- fan_serial_device.sv
`timescale 1ns/100ps
`default_nettype none
module fan_serial_device
  import fan_port_pkg::*;
(
  input  wire logic        clk_sys,
  input  wire logic        rst_n,
  fan_link_if.device       link,
  input  wire logic        tach_pulse,
  output logic [8:0]       duty_demand,
  output logic             serial_mode,
  output logic             post_coast_long,
  output logic             standby_disable,
  output logic [1:0]       drive_freq_select,
  output logic             temp_comp_enable,
  output logic [1:0]       overcurrent_level,
  output logic             overcurrent_limit_off,
  output logic             feedback_loop_select,
  output logic             advance_mode_select,
  output logic             speed_source_select,
  output logic [3:0]       pole_pairs,
  output logic             coast_disable,
  output logic             rotor_alignment_style,
  output logic             tach_during_startup,
  output logic             overcurrent_recovery_select,
  output logic [14:0]      slope_switch_speed
);
  import fan_port_pkg::*;

  typedef enum {ST_IDLE, ST_ADDR, ST_ADDR_ACK, ST_REG, ST_REG_ACK, ST_WDATA, ST_WACK,
                ST_RDATA, ST_RACK, ST_SKIP} state_t;

  logic [1:0]  pins;
  logic        scl_s, sda_s, scl_d, sda_d;
  logic [15:0] nv_word [NV_WORDS];
  logic [8:0]  direct_duty_command;
  logic [7:0]  register_number;
  logic [7:0]  shift;
  logic [2:0]  bit_cnt;
  logic        byte_idx;
  logic        rw;
  logic        seen_command;
  logic        pwm_level;
  logic        sda_low;
  logic [15:0] hold_data;
  state_t      state;

  pin_sync #(.W(2)) u_sync (
    .clk_sys (clk_sys),
    .rst_n   (rst_n),
    .raw     ({link.scl, link.sda}),
    .synced  (pins)
  );
  assign scl_s = pins[1];
  assign sda_s = pins[0];

  wire scl_rise  = scl_s & ~scl_d;
  wire scl_fall  = ~scl_s & scl_d;
  wire start_c   = scl_s & scl_d & sda_d & ~sda_s;
  wire stop_c    = scl_s & scl_d & ~sda_d & sda_s;
  wire [7:0] sh_next = {shift[6:0], sda_s};
  wire addr_hit  = sh_next[7:1] == SLAVE_ADDR;
  wire reg_param = register_number >= PARAM_FIRST && register_number <= PARAM_LAST;
  wire reg_word  = register_number < 8'(NV_WORDS) && register_number != 8'h00;
  wire [4:0] widx = reg_param ? 5'(register_number - PARAM_BASE) : register_number[4:0];
  wire [15:0] rd_word = (register_number == DUTY_REG) ? {7'h00, direct_duty_command}
                      : (reg_param || reg_word) ? nv_word[widx] : 16'h0000;
  wire [15:0] wr_word = {hold_data[7:0], sh_next};
  wire [15:0] w15 = nv_word[W_DRIVE];
  wire [15:0] w16 = nv_word[W_RUN];

  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      scl_d <= 1'b1;
      sda_d <= 1'b1;
    end else begin
      scl_d <= scl_s;
      sda_d <= sda_s;
    end
  end

  // Speed line level, sampled every cycle, stands for the duty input outside serial mode
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) pwm_level <= 1'b0;
    else        pwm_level <= scl_s;
  end

  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      state        <= ST_IDLE;
      shift        <= 8'h00;
      bit_cnt      <= 3'd0;
      byte_idx     <= 1'b0;
      rw           <= 1'b0;
      sda_low      <= 1'b0;
      seen_command <= 1'b0;
      register_number     <= 8'h00;
      hold_data           <= 16'h0000;
      direct_duty_command <= DUTY_RESET;
      for (int i = 0; i < NV_WORDS; i++) nv_word[i] <= 16'h0000;
      nv_word[W_DRIVE]       <= DRIVE_RESET;
      nv_word[W_RUN]         <= RUN_RESET;
      nv_word[W_SLOPE_SPEED] <= SLOPE_SPEED_RESET;
    end else if (start_c) begin
      state   <= ST_ADDR;
      bit_cnt <= 3'd0;
      sda_low <= 1'b0;
    end else if (stop_c) begin
      state   <= ST_IDLE;
      sda_low <= 1'b0;
    end else begin
      unique case (state)
        ST_IDLE: sda_low <= 1'b0;
        ST_ADDR, ST_REG, ST_WDATA: if (scl_rise) begin
          shift   <= sh_next;
          bit_cnt <= bit_cnt + 3'd1;
          if (bit_cnt == 3'd7) begin
            if (state == ST_ADDR) begin
              rw    <= sda_s;
              state <= addr_hit ? ST_ADDR_ACK : ST_SKIP;
              seen_command <= seen_command | addr_hit;
              hold_data    <= rd_word;
              byte_idx     <= 1'b0;
            end else if (state == ST_REG) begin
              register_number <= sh_next;
              state    <= ST_REG_ACK;
              byte_idx <= 1'b0;
            end else begin
              state <= ST_WACK;
              if (!byte_idx) hold_data[7:0] <= sh_next;
              else if (register_number == DUTY_REG)
                direct_duty_command <= wr_word[8:0];
              else if (reg_param)
                nv_word[widx] <= wr_word;
            end
          end
        end
        ST_ADDR_ACK, ST_REG_ACK, ST_WACK: begin
          if (scl_fall && !sda_low) sda_low <= 1'b1;
          else if (scl_fall && sda_low) begin
            sda_low <= 1'b0;
            bit_cnt <= 3'd0;
            if (state == ST_ADDR_ACK && rw) begin
              state   <= ST_RDATA;
              sda_low <= ~hold_data[15];
            end else if (state == ST_ADDR_ACK) state <= ST_REG;
            else begin
              state    <= ST_WDATA;
              byte_idx <= state == ST_WACK ? ~byte_idx : 1'b0;
            end
          end
        end
        ST_RDATA: if (scl_fall) begin
          bit_cnt   <= bit_cnt + 3'd1;
          hold_data <= {hold_data[14:0], 1'b0};
          if (bit_cnt == 3'd7) begin
            state   <= ST_RACK;
            sda_low <= 1'b0;
          end else sda_low <= ~hold_data[14];
        end
        ST_RACK: if (scl_rise && sda_s) begin
          // Master nack ends the read; an ack waits for the fall
          state <= ST_SKIP;
        end else if (scl_fall) begin
          // Low byte MSB goes out on this fall, not one bit later
          state   <= ST_RDATA;
          bit_cnt <= 3'd0;
          sda_low <= ~hold_data[15];
        end
        default: sda_low <= 1'b0;
      endcase
    end
  end

  // Tach output shares the data pin; it may hold the line low until the first serial command
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      link.sda_device_out  <= 1'b1;
      link.sda_device_oe_n <= 1'b1;
    end else begin
      link.sda_device_out  <= 1'b0;
      link.sda_device_oe_n <= ~(sda_low | (tach_pulse & ~seen_command));
    end
  end

  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      duty_demand  <= DUTY_ZERO;
      serial_mode  <= 1'b0;
      post_coast_long       <= 1'b1;
      standby_disable       <= 1'b0;
      drive_freq_select     <= 2'b10;
      temp_comp_enable      <= 1'b0;
      overcurrent_level     <= 2'b00;
      overcurrent_limit_off <= 1'b0;
      feedback_loop_select  <= 1'b1;
      advance_mode_select   <= 1'b0;
      speed_source_select   <= 1'b0;
      pole_pairs            <= 4'd2;
      coast_disable         <= 1'b1;
      rotor_alignment_style <= 1'b1;
      tach_during_startup   <= 1'b0;
      overcurrent_recovery_select <= 1'b0;
      slope_switch_speed    <= 15'h07d0;
    end else begin
      serial_mode <= seen_command;
      // Serial session drops duty to zero until register 165 is written
      duty_demand <= seen_command ? direct_duty_command
                   : (pwm_level ? DUTY_FULL : DUTY_ZERO);
      post_coast_long       <= w15[POST_COAST_BIT];
      standby_disable       <= w15[STANDBY_OFF_BIT];
      drive_freq_select     <= w15[FREQ_LO +: 2];
      temp_comp_enable      <= w15[TEMP_COMP_BIT];
      overcurrent_level     <= w15[OC_LEVEL_LO +: 2];
      overcurrent_limit_off <= w15[OC_OFF_BIT];
      feedback_loop_select  <= w16[LOOP_BIT];
      advance_mode_select   <= w16[ADVANCE_BIT];
      speed_source_select   <= w16[SOURCE_BIT];
      pole_pairs            <= {1'b0, w16[POLE_LO +: 3]} + 4'd1;
      coast_disable         <= w16[NO_COAST_BIT];
      rotor_alignment_style <= w16[ALIGN_BIT];
      tach_during_startup   <= w16[TACH_START_BIT];
      overcurrent_recovery_select <= w16[OC_RECOVERY_BIT];
      slope_switch_speed    <= nv_word[W_SLOPE_SPEED][SLOPE_SPEED_W-1:0];
    end
  end
endmodule
`default_nettype wire

//--- fan_serial_master.sv
`timescale 1ns/100ps
`default_nettype none
module fan_serial_master
  import fan_port_pkg::*;
(
  input  wire logic        clk_sys,
  input  wire logic        rst_n,
  fan_link_if.master       link,
  input  wire logic        cmd_valid,
  input  wire logic        cmd_read,
  input  wire logic [7:0]  cmd_register,
  input  wire logic [15:0] cmd_data,
  output logic             cmd_busy,
  output logic             rsp_valid,
  output logic [15:0]      rsp_data,
  output logic             rsp_nack,
  input  wire logic        hold_lines_low
);
  import fan_port_pkg::*;

  typedef enum {M_IDLE, M_START, M_BIT, M_STOP, M_GAP} mstate_t;

  logic [1:0]  pins;
  logic [5:0]  div;
  logic [1:0]  phase;
  logic [5:0]  nbits;
  logic [47:0] tx;
  logic [47:0] rx;
  logic [47:0] drive_mask;
  logic        second;
  logic        rd_op;
  logic [7:0]  reg_keep;
  mstate_t     st;

  pin_sync #(.W(2)) u_sync (
    .clk_sys (clk_sys),
    .rst_n   (rst_n),
    .raw     ({link.scl, link.sda}),
    .synced  (pins)
  );

  wire tick = div == 6'(SCL_HALF - 1);
  // Frames: addr+ack, reg+ack, two bytes+acks (write) or addr+ack, reg+ack, then a new frame of addr+ack, two bytes+acks (read)
  wire [7:0] addr_w = {SLAVE_ADDR, 1'b0};
  wire [7:0] addr_r = {SLAVE_ADDR, 1'b1};

  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      st <= M_IDLE; div <= 6'd0; phase <= 2'd0; nbits <= 6'd0;
      tx <= 48'h0; rx <= 48'h0; drive_mask <= 48'h0; second <= 1'b0; rd_op <= 1'b0;
      reg_keep <= 8'h00; cmd_busy <= 1'b0; rsp_valid <= 1'b0; rsp_data <= 16'h0000;
      rsp_nack <= 1'b0;
      link.scl_out <= 1'b0; link.scl_oe_n <= 1'b1;
      link.sda_master_out <= 1'b0; link.sda_master_oe_n <= 1'b1;
    end else begin
      rsp_valid <= 1'b0;
      div <= tick ? 6'd0 : div + 6'd1;
      unique case (st)
        M_IDLE: begin
          link.scl_oe_n       <= ~hold_lines_low;
          link.sda_master_oe_n <= ~hold_lines_low;
          if (cmd_valid && !hold_lines_low) begin
            cmd_busy <= 1'b1; rd_op <= cmd_read; reg_keep <= cmd_register; second <= 1'b0;
            rsp_nack <= 1'b0; st <= M_START; div <= 6'd0;
            tx <= cmd_read ? {addr_w, 1'b1, cmd_register, 1'b1, 30'h0}
                           : {addr_w, 1'b1, cmd_register, 1'b1, cmd_data[15:8], 1'b1,
                              cmd_data[7:0], 1'b1, 12'h0};
            nbits <= cmd_read ? 6'd18 : 6'd36;
            // Device ack slots; a high level there is a nack
            drive_mask <= cmd_read ? {8'h00, 1'b1, 8'h00, 1'b1, 30'h0}
                        : {8'h00, 1'b1, 8'h00, 1'b1, 8'h00, 1'b1, 8'h00, 1'b1, 12'h0};
          end
        end
        M_START: if (tick) begin
          link.sda_master_oe_n <= 1'b0; // SDA falls while SCL high
          link.scl_oe_n <= 1'b1;
          phase <= 2'd0; st <= M_BIT;
        end
        M_BIT: if (tick) begin
          phase <= phase + 2'd1;
          unique case (phase)
            2'd0: begin
              link.scl_oe_n <= 1'b0;
              link.sda_master_oe_n <= tx[47];
            end
            2'd1: link.scl_oe_n <= 1'b1;
            2'd2: begin
              // Clock stretching is not supported; the device never holds SCL
              rx <= {rx[46:0], pins[0]};
              if (drive_mask[47] && pins[0]) rsp_nack <= 1'b1;
              tx <= {tx[46:0], 1'b1};
              drive_mask <= {drive_mask[46:0], 1'b0};
              nbits <= nbits - 6'd1;
              phase <= 2'd0;
              if (nbits == 6'd1) st <= M_STOP;
            end
            default: phase <= 2'd0;
          endcase
        end
        M_STOP: if (tick) begin
          phase <= phase + 2'd1;
          if (phase == 2'd0) begin
            link.scl_oe_n <= 1'b0; link.sda_master_oe_n <= 1'b0;
          end else if (phase == 2'd1) link.scl_oe_n <= 1'b1;
          else begin
            link.sda_master_oe_n <= 1'b1; phase <= 2'd0; st <= M_GAP;
          end
        end
        M_GAP: if (tick) begin
          if (rd_op && !second) begin
            second <= 1'b1; st <= M_START;
            tx <= {addr_r, 1'b1, 8'hff, 1'b0, 8'hff, 1'b1, 21'h1fffff};
            nbits <= 6'd27;
            drive_mask <= {8'h00, 1'b1, 39'h0};
          end else begin
            if (rd_op) begin
              rsp_data  <= {rx[17:10], rx[8:1]};
              rsp_valid <= 1'b1;
            end
            cmd_busy <= 1'b0; st <= M_IDLE;
          end
        end
        default: st <= M_IDLE;
      endcase
    end
  end
endmodule
`default_nettype wire

//--- fan_link_chk.sv
`timescale 1ns/100ps
`default_nettype none
module fan_link_chk
  import fan_port_pkg::*;
(
  input wire logic clk_sys,
  input wire logic rst_n,
  input wire logic scl,
  input wire logic sda,
  input wire logic sda_master_oe_n,
  input wire logic sda_device_out,
  input wire logic sda_device_oe_n
);
  import fan_port_pkg::*;

  logic       scl_q;
  logic       sda_q;
  logic [3:0] bit_cnt;
  logic [2:0] byte_idx;
  logic [7:0] shift;
  logic       rd_frame;
  logic       framed;
  // Tach pull-down is not a start
  wire scl_rise   = scl && !scl_q;
  wire start_seen = scl && scl_q && sda_q && !sda && sda_device_oe_n;
  wire ack_slot   = scl_rise && bit_cnt == 4'h8;
  wire data_slot  = scl_rise && bit_cnt != 4'h8;

  default clocking @(posedge clk_sys); endclocking
  default disable iff (!rst_n);

  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      scl_q <= 1'b1;
      sda_q <= 1'b1;
      bit_cnt <= 4'h0;
      byte_idx <= 3'h0;
      shift <= 8'h00;
      rd_frame <= 1'b0;
      framed <= 1'b0;
    end else begin
      scl_q <= scl;
      sda_q <= sda;
      framed <= framed | start_seen;
      if (start_seen) begin
        bit_cnt <= 4'h0;
        byte_idx <= 3'h0;
      end else if (ack_slot) begin
        bit_cnt <= 4'h0;
        byte_idx <= byte_idx + 3'h1;
      end else if (data_slot) begin
        bit_cnt <= bit_cnt + 4'h1;
        shift <= {shift[6:0], sda};
      end
      if (ack_slot && byte_idx == 3'h0) begin
        rd_frame <= shift[0];
      end
    end
  end

  addr_ack_a: assert property (
    ack_slot && byte_idx == 3'h0 && shift[7:1] == SLAVE_ADDR |-> !sda)
    else $error("address byte not acknowledged");
  write_data_ack_a: assert property (
    ack_slot && !rd_frame && byte_idx inside {[3'h1:3'h3]} |-> !sda)
    else $error("write byte not acknowledged");
  read_ack_a: assert property (
    ack_slot && rd_frame && byte_idx == 3'h1 |-> !sda)
    else $error("first read byte not acknowledged by master");
  read_nack_a: assert property (
    ack_slot && rd_frame && byte_idx == 3'h2 |-> sda)
    else $error("last read byte not refused by master");
  dev_release_a: assert property (
    framed && data_slot && (byte_idx == 3'h0 || !rd_frame) |-> sda_device_oe_n)
    else $error("device drives data during master bits");
  master_release_a: assert property (
    data_slot && rd_frame && byte_idx inside {[3'h1:3'h2]} |-> sda_master_oe_n)
    else $error("master drives data during read bits");
  open_drain_a: assert property (
    !sda_device_oe_n |-> !sda_device_out)
    else $error("device drives data line high");
  dev_edge_a: assert property (
    framed && $changed(sda_device_oe_n) |-> !scl)
    else $error("device changed data while clock high");
  start_clock_a: assert property (
    start_seen |-> ##[1:100] !scl)
    else $error("no clock after start");

  cover property (start_seen);
  cover property (ack_slot && !rd_frame && byte_idx == 3'h3);
  cover property (ack_slot && rd_frame && byte_idx == 3'h2);
endmodule
`default_nettype wire

//--- tb_fan_driver_serial_control_port.sv
`timescale 1ns/100ps
`default_nettype none
module tb_fan_driver_serial_control_port;
  import fan_port_pkg::*;
  logic        clk_sys;
  logic        rst_n;
  logic        tach_pulse;
  logic        cmd_valid;
  logic        cmd_read;
  logic [7:0]  cmd_register;
  logic [15:0] cmd_data;
  logic        hold_lines_low;
  logic        cmd_busy;
  logic        rsp_valid;
  logic [15:0] rsp_data;
  logic        rsp_nack;
  logic [8:0]  duty_demand;
  logic        serial_mode;
  logic        post_coast_long, standby_disable, temp_comp_enable;
  logic [1:0]  drive_freq_select, overcurrent_level;
  logic        overcurrent_limit_off, feedback_loop_select, advance_mode_select;
  logic        speed_source_select, coast_disable, rotor_alignment_style;
  logic        tach_during_startup, overcurrent_recovery_select;
  logic [3:0]  pole_pairs;
  logic [14:0] slope_switch_speed;
  logic [15:0] drive_seen;
  logic [15:0] run_seen;
  logic [15:0] vals [2];
  int          error_cnt;
  int          cmp_count;
  int          cyc;

  fan_link_if link_if();

  fan_serial_device fan_serial_device_inst (.clk_sys(clk_sys), .rst_n(rst_n),
    .link(link_if.device), .tach_pulse(tach_pulse), .duty_demand(duty_demand),
    .serial_mode(serial_mode), .post_coast_long(post_coast_long),
    .standby_disable(standby_disable), .drive_freq_select(drive_freq_select),
    .temp_comp_enable(temp_comp_enable), .overcurrent_level(overcurrent_level),
    .overcurrent_limit_off(overcurrent_limit_off),
    .feedback_loop_select(feedback_loop_select),
    .advance_mode_select(advance_mode_select),
    .speed_source_select(speed_source_select), .pole_pairs(pole_pairs),
    .coast_disable(coast_disable), .rotor_alignment_style(rotor_alignment_style),
    .tach_during_startup(tach_during_startup),
    .overcurrent_recovery_select(overcurrent_recovery_select),
    .slope_switch_speed(slope_switch_speed));

  fan_serial_master fan_serial_master_inst (.clk_sys(clk_sys), .rst_n(rst_n),
    .link(link_if.master), .cmd_valid(cmd_valid), .cmd_read(cmd_read),
    .cmd_register(cmd_register), .cmd_data(cmd_data), .cmd_busy(cmd_busy),
    .rsp_valid(rsp_valid), .rsp_data(rsp_data), .rsp_nack(rsp_nack),
    .hold_lines_low(hold_lines_low));

  fan_link_chk fan_link_chk_inst (.clk_sys(clk_sys), .rst_n(rst_n),
    .scl(link_if.scl), .sda(link_if.sda), .sda_master_oe_n(link_if.sda_master_oe_n),
    .sda_device_out(link_if.sda_device_out),
    .sda_device_oe_n(link_if.sda_device_oe_n));

  assign drive_seen = {overcurrent_limit_off, overcurrent_level, 6'h00, temp_comp_enable,
                       2'h0, drive_freq_select, standby_disable, post_coast_long};
  assign run_seen = {overcurrent_recovery_select, 3'h0, tach_during_startup, 2'h0,
                     rotor_alignment_style, coast_disable, 3'h0, speed_source_select,
                     1'b0, advance_mode_select, feedback_loop_select};

  initial begin
    clk_sys = 1'b0;
    forever #12.5 clk_sys = ~clk_sys;
  end

  task automatic end_sim();
    $display("Comparisons %0d mismatches %0d", cmp_count, error_cnt);
    if (error_cnt == 0 && cmp_count > 0) begin
      $display("All tests passed");
    end else begin
      $display("Some tests failed");
    end
    $finish;
  endtask

  // Budget well above the expected run length
  always @(posedge clk_sys) begin
    cyc++;
    if (cyc == 100000) begin
      error_cnt++;
      end_sim();
    end
  end

  task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
    cmp_count++;
    if (seen !== exp) begin
      error_cnt++;
      $display("[FAIL] %0t seen %h expected %h", $time, seen, exp);
    end
  endtask

  // Valid held until busy is seen, as the master only samples it in idle
  task automatic do_cmd(input logic rd, input logic [7:0] rn, input logic [15:0] d);
    int n;
    logic rv;
    n = 0;
    @(posedge clk_sys);
    cmd_valid <= 1'b1;
    cmd_read <= rd;
    cmd_register <= rn;
    cmd_data <= d;
    while (cmd_busy !== 1'b1 && n < 200) begin
      @(posedge clk_sys);
      n++;
    end
    cmd_valid <= 1'b0;
    while (cmd_busy !== 1'b0) @(posedge clk_sys);
    // Pulse launched with the fall of busy is still visible at this edge
    rv = rsp_valid;
    @(negedge clk_sys);
    chk({15'h0, rsp_nack}, 16'h0000);
    chk({15'h0, rv}, {15'h0, rd});
  endtask

  task automatic chk_cfg(input logic [15:0] d, input logic [15:0] r, input logic [15:0] s);
    chk(drive_seen, d & 16'he04f);
    chk(run_seen, r & 16'h898b);
    chk({12'h000, pole_pairs}, {13'h0000, r[6:4]} + 16'h0001);
    chk({1'b0, slope_switch_speed}, s & 16'h7fff);
  endtask

  initial begin
    rst_n = 1'b0;
    tach_pulse = 1'b0;
    cmd_valid = 1'b0;
    cmd_read = 1'b0;
    cmd_register = 8'h00;
    cmd_data = 16'h0000;
    hold_lines_low = 1'b1;
    vals[0] = 16'hffff;
    vals[1] = 16'h5a5a;
    repeat (20) @(posedge clk_sys);
    rst_n <= 1'b1;
    repeat (10) @(negedge clk_sys);
    chk({7'h00, duty_demand}, 16'h0000);
    chk({15'h0, serial_mode}, 16'h0000);
    chk_cfg(DRIVE_RESET, RUN_RESET, SLOPE_SPEED_RESET);
    @(posedge clk_sys);
    hold_lines_low <= 1'b0;
    tach_pulse <= 1'b1;
    repeat (10) @(negedge clk_sys);
    chk({7'h00, duty_demand}, {7'h00, DUTY_FULL});
    chk({15'h0, link_if.sda}, 16'h0000);
    @(posedge clk_sys);
    tach_pulse <= 1'b0;
    repeat (10) @(negedge clk_sys);
    chk({15'h0, link_if.sda}, 16'h0001);
    do_cmd(1'b0, PARAM_FIRST, 16'h1234);
    chk({15'h0, serial_mode}, 16'h0001);
    chk({7'h00, duty_demand}, 16'h0000);
    do_cmd(1'b1, PARAM_FIRST, 16'h0000);
    chk(rsp_data, 16'h1234);
    do_cmd(1'b1, 8'h01, 16'h0000);
    chk(rsp_data, 16'h1234);
    do_cmd(1'b0, PARAM_LAST, 16'hbeef);
    do_cmd(1'b1, 8'h14, 16'h0000);
    chk(rsp_data, 16'hbeef);
    foreach (vals[i]) begin
      do_cmd(1'b0, 8'(PARAM_BASE + W_DRIVE), vals[i]);
      do_cmd(1'b0, 8'(PARAM_BASE + W_RUN), vals[i]);
      do_cmd(1'b0, 8'(PARAM_BASE + W_SLOPE_SPEED), vals[i]);
      chk_cfg(vals[i], vals[i], vals[i]);
      do_cmd(1'b1, 8'(W_RUN), 16'h0000);
      chk(rsp_data, vals[i]);
      do_cmd(1'b1, 8'(PARAM_BASE + W_DRIVE), 16'h0000);
      chk(rsp_data, vals[i]);
    end
    // Upper bits must be dropped, not wrapped into the duty
    do_cmd(1'b0, DUTY_REG, 16'hfe66);
    chk({7'h00, duty_demand}, 16'h0066);
    do_cmd(1'b1, DUTY_REG, 16'h0000);
    chk(rsp_data, 16'h0066);
    do_cmd(1'b0, DUTY_REG, 16'h01ff);
    chk({7'h00, duty_demand}, {7'h00, DUTY_FULL});
    do_cmd(1'b1, 8'h30, 16'h0000);
    chk(rsp_data, 16'h0000);
    end_sim();
  end
endmodule
`default_nettype wire
